/* File: wwd_top.sv */
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - time-out before a valid clear requests a system reset
// - time base picked from three slow oscillator ticks by config or field
// - mode 11 runs always, sleep included, ignoring the software enable
// - mode 10 runs awake and stops in sleep
// - mode 01 runs only while the software enable is set
// - mode 00 never runs
// - prescale field sets 1 ms to 256 s, reset default 2 s
// - windowed clear outside the open window is a violation reset
// - window from config code unless that code is 111, then from ctrl1
// - open window from 12.5 to 100 percent of the period
// - violation clears active-low flag; power-on sets it, firmware may set
// - counter cleared by reset, clear, sleep edges, disable, ost, ctrl0 and ctrl1 writes
// - windowed clear needs a prior ctrl0 read, else violation
// - code 0 divides by 32, doubling to code 18; higher codes act as 0
// - open share 12.5 percent per code step; 111 fully open
// - time-out in sleep wakes the device instead of resetting
// - time-out in idle wakes the device instead of resetting
module wwd_top (
	// clock, reset, enable
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	input  wire logic       por_i,
	// configuration straps
	input  wire logic [1:0] mode_cfg_i,
	input  wire logic [4:0] prescale_cfg_i,
	input  wire logic [2:0] timebase_cfg_i,
	input  wire logic [2:0] window_cfg_i,
	// time base ticks from the slow oscillators (async)
	input  wire logic       tick_lf_i,
	input  wire logic       tick_mf_i,
	input  wire logic       tick_secondary_osc_i,
	// cpu status
	input  wire logic       sleep_i,
	input  wire logic       idle_i,
	input  wire logic       ost_busy_i,
	input  wire logic       clear_op_i,
	// register port
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic [7:0]      rdata_o,
	// reset controller and wake
	output logic            rst_req_o,
	output logic            rst_cause_o,
	output logic            wake_o,
	output logic            timeout_flag_n_o
);
	// synchronisers for the three asynchronous ticks
	logic [2:0] tk_s1_r, tk_s2_r, tk_s3_r;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			tk_s1_r <= 3'h0;
			tk_s2_r <= 3'h0;
			tk_s3_r <= 3'h0;
		end else if (ce_i) begin
			tk_s1_r <= {tick_secondary_osc_i, tick_mf_i, tick_lf_i};
			tk_s2_r <= tk_s1_r;
			tk_s3_r <= tk_s2_r;
		end
	end

	// counter width comes first, the counter declaration below needs it
	localparam int CNT_W = wwd_pkg::CNT_W;

	// register state
	logic [4:0] ps_r;
	logic       swon_r;
	logic [2:0] tb_r;
	logic [2:0] win_r;
	logic       wv_n_r;
	logic       armed_r;
	logic       sleep_q_r;
	logic       en_q_r;
	logic [CNT_W-1:0] cnt_r;

	// strap-driven locks: field writable only when strap is reserved code
	wire ps_wr_ok  = (prescale_cfg_i == 5'h1f);
	wire tb_wr_ok  = (timebase_cfg_i == wwd_pkg::TB_RESERVED);
	wire win_wr_ok = (window_cfg_i == wwd_pkg::WIN_FULL);
	wire wr_c0 = wr_i && (addr_i == wwd_pkg::OFF_CTRL0);
	wire wr_c1 = wr_i && (addr_i == wwd_pkg::OFF_CTRL1);
	wire wr_pc = wr_i && (addr_i == wwd_pkg::OFF_POWER_CONTROL_REG);
	wire rd_c0 = rd_i && (addr_i == wwd_pkg::OFF_CTRL0);

	// enable per mode
	wire running =
		(mode_cfg_i == wwd_pkg::MODE_ON) ||
		((mode_cfg_i == wwd_pkg::MODE_AWAKE) && !sleep_i) ||
		((mode_cfg_i == wwd_pkg::MODE_SOFT) && swon_r);
	// mode 00 never matches above, so the counter stays off

	// tick select; strap wins unless it is the reserved code
	wire [2:0] tb_sel = tb_wr_ok ? tb_r : timebase_cfg_i;
	wire [2:0] edge_v = tk_s2_r & ~tk_s3_r;
	wire tick = (tb_sel == wwd_pkg::TB_LFINT) ? edge_v[0] :
		(tb_sel == wwd_pkg::TB_MFINT) ? edge_v[1] :
		(tb_sel == wwd_pkg::TB_SECONDARY_OSC) ? edge_v[2] : 1'b0;

	// period: 2^(5+code) ticks, reserved codes behave like 0
	wire [4:0] ps_eff = (ps_r > wwd_pkg::PS_MAX) ? 5'h00 : ps_r;
	wire [4:0] sh     = ps_eff + 5'(wwd_pkg::BASE_DIV_LOG2);
	wire [CNT_W:0] period = (CNT_W+1)'(1) << sh;
	wire [CNT_W:0] cnt_x  = {1'b0, cnt_r};
	wire expire = running && tick && ((cnt_x + (CNT_W+1)'(1)) >= period);

	// window: closed share = (7-code)/8 of period
	wire [2:0] win_sel = win_wr_ok ? win_r : window_cfg_i;
	wire [2:0] closed8 = 3'h7 - win_sel;
	wire [CNT_W+3:0] lhs = {cnt_x, 3'h0};
	wire [CNT_W+3:0] rhs = (CNT_W+4)'(period) * (CNT_W+4)'(closed8);
	wire win_open = (lhs >= rhs);
	wire windowed = (win_sel != wwd_pkg::WIN_FULL);

	// a clear is valid when not windowed, or armed and inside window
	wire clr_ok  = clear_op_i && (!windowed || (armed_r && win_open));
	wire violate = running && clear_op_i && !clr_ok;
	wire asleep  = sleep_i || idle_i;
	wire sleep_edge = (sleep_i != sleep_q_r);
	wire disable_edge = en_q_r && !running;
	wire cnt_clr = clr_ok || sleep_edge || disable_edge ||
		ost_busy_i || wr_c0 || wr_c1 || !running;

	// counter and arming; arming drops whenever counter clears
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			cnt_r     <= '0;
			armed_r   <= 1'b0;
			sleep_q_r <= 1'b0;
			en_q_r    <= 1'b0;
		end else if (ce_i) begin
			sleep_q_r <= sleep_i;
			en_q_r    <= running;
			if (cnt_clr || expire || violate) begin
				cnt_r   <= '0;
				armed_r <= 1'b0;
			end else begin
				if (tick)
					cnt_r <= cnt_r + CNT_W'(1);
				if (rd_c0)
					armed_r <= 1'b1;
			end
		end
	end

	// field registers, power-on defaults follow straps, rst_i loads fixed values
	wire [4:0] ps_rst = ps_wr_ok ? wwd_pkg::PS_RESET : prescale_cfg_i;
	wire [2:0] tb_rst = tb_wr_ok ? wwd_pkg::TB_LFINT : timebase_cfg_i;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ps_r   <= wwd_pkg::PS_RESET;
			swon_r <= 1'b0;
			tb_r   <= wwd_pkg::TB_LFINT;
			win_r  <= wwd_pkg::WIN_FULL;
		end else if (ce_i) begin
			if (por_i) begin
				ps_r  <= ps_rst;
				tb_r  <= tb_rst;
				win_r <= window_cfg_i;
			end else begin
				if (wr_c0) begin
					swon_r <= wdata_i[wwd_pkg::CTRL0_SWON_BIT];
					if (ps_wr_ok)
						ps_r <= wdata_i[wwd_pkg::CTRL0_PS_LSB +: 5];
				end
				if (wr_c1 && tb_wr_ok)
					tb_r <= wdata_i[wwd_pkg::CTRL1_TB_LSB +: 3];
				if (wr_c1 && win_wr_ok)
					win_r <= wdata_i[wwd_pkg::CTRL1_WIN_LSB +: 3];
			end
		end
	end

	// violation flag: hardware clear beats firmware set
	always_ff @(posedge clock_i) begin
		if (rst_i)
			wv_n_r <= 1'b1;
		else if (ce_i) begin
			if (violate)
				wv_n_r <= 1'b0;
			else if (por_i)
				wv_n_r <= 1'b1;
			else if (wr_pc && wdata_i[wwd_pkg::POWER_CONTROL_REG_WV_BIT])
				wv_n_r <= 1'b1;
		end
	end

	// reset request or wake; asleep timeouts never reset
	wire to_reset = expire && !asleep;
	wire to_wake  = expire && asleep;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rst_req_o        <= 1'b0;
			rst_cause_o      <= 1'b0;
			wake_o           <= 1'b0;
			timeout_flag_n_o <= 1'b1;
		end else if (ce_i) begin
			rst_req_o <= to_reset || violate;
			if (to_reset || violate)
				rst_cause_o <= violate;
			wake_o <= to_wake;
			if (expire)
				timeout_flag_n_o <= 1'b0;
			else if (clr_ok)
				timeout_flag_n_o <= 1'b1;
		end else begin
			rst_req_o <= 1'b0;
			wake_o    <= 1'b0;
		end
	end

	// read mux; unmapped reads return zero
	wire [7:0] rd_mux =
		(addr_i == wwd_pkg::OFF_CTRL0) ? {2'h0, ps_r, swon_r} :
		(addr_i == wwd_pkg::OFF_CTRL1) ? {1'b0, tb_sel, 1'b0, win_sel} :
		(addr_i == wwd_pkg::OFF_POWER_CONTROL_REG)  ? {7'h0, wv_n_r} :
		(addr_i == wwd_pkg::OFF_STATUS) ?
			{5'h0, armed_r, win_open, running} : 8'h00;
	always_ff @(posedge clock_i) begin
		if (rst_i)
			rdata_o <= 8'h00;
		else if (ce_i)
			rdata_o <= rd_i ? rd_mux : 8'h00;
	end

	// checks
	property p_violate_req;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && violate) |=> (rst_req_o && rst_cause_o && !wv_n_r);
	endproperty
	a_violate_req: assert property (p_violate_req)
		else $error("violation did not request reset");

	property p_timeout_req;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && expire && !asleep && !violate) |=>
			(rst_req_o && !rst_cause_o);
	endproperty
	a_timeout_req: assert property (p_timeout_req)
		else $error("timeout did not request reset");

	property p_sleep_wake;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && expire && asleep) |=> (wake_o && !$past(to_reset));
	endproperty
	a_sleep_wake: assert property (p_sleep_wake)
		else $error("asleep timeout did not wake");

	property p_off_mode;
		@(posedge clock_i) disable iff (rst_i)
		(mode_cfg_i == wwd_pkg::MODE_OFF) |-> (!expire && !violate);
	endproperty
	a_off_mode: assert property (p_off_mode)
		else $error("disabled watchdog acted");

	property p_clear_zero;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && (wr_c0 || wr_c1)) |=> (cnt_r == '0);
	endproperty
	a_clear_zero: assert property (p_clear_zero)
		else $error("write did not clear counter");

	property p_unarmed;
		@(posedge clock_i) disable iff (rst_i)
		(running && windowed && clear_op_i && !armed_r) |-> violate;
	endproperty
	a_unarmed: assert property (p_unarmed)
		else $error("unarmed clear not flagged");

	property p_req_pulse;
		@(posedge clock_i) disable iff (rst_i)
		rst_req_o |=> !rst_req_o || $past(violate || to_reset);
	endproperty
	a_req_pulse: assert property (p_req_pulse)
		else $error("reset request held");

	property p_sleep_stop;
		@(posedge clock_i) disable iff (rst_i)
		(mode_cfg_i == wwd_pkg::MODE_AWAKE && sleep_i) |-> !running;
	endproperty
	a_sleep_stop: assert property (p_sleep_stop)
		else $error("mode 10 ran in sleep");

	property p_always_on;
		@(posedge clock_i) disable iff (rst_i)
		(mode_cfg_i == wwd_pkg::MODE_ON) |-> running;
	endproperty
	a_always_on: assert property (p_always_on)
		else $error("mode 11 stopped");

	property p_soft_off;
		@(posedge clock_i) disable iff (rst_i)
		(mode_cfg_i == wwd_pkg::MODE_SOFT && !swon_r) |-> !running;
	endproperty
	a_soft_off: assert property (p_soft_off)
		else $error("mode 01 ran with software enable low");

	property p_idle_wake;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && expire && asleep && !violate) |=> !rst_req_o;
	endproperty
	a_idle_wake: assert property (p_idle_wake)
		else $error("asleep timeout requested reset");

	property p_por_flag;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && por_i && !violate) |=> wv_n_r;
	endproperty
	a_por_flag: assert property (p_por_flag)
		else $error("power-on did not set violation flag");

	property p_valid_clear;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && clr_ok) |=> (cnt_r == '0 && !armed_r);
	endproperty
	a_valid_clear: assert property (p_valid_clear)
		else $error("valid clear left counter or arming");

	property p_arm_read;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && rd_c0 && !cnt_clr && !expire && !violate) |=> armed_r;
	endproperty
	a_arm_read: assert property (p_arm_read)
		else $error("ctrl0 read did not arm");

	property p_count_step;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && tick && !cnt_clr && !expire && !violate) |=>
			(cnt_r == $past(cnt_r) + CNT_W'(1));
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("counter missed a tick");

	property p_sleep_clear;
		@(posedge clock_i) disable iff (rst_i)
		(ce_i && sleep_edge) |=> (cnt_r == '0);
	endproperty
	a_sleep_clear: assert property (p_sleep_clear)
		else $error("sleep change did not clear counter");
endmodule

/* File: wwd_pkg.sv */
package wwd_pkg;
	// register offsets (one aligned word each)
	localparam logic [3:0] OFF_CTRL0  = 4'h0;
	localparam logic [3:0] OFF_CTRL1  = 4'h4;
	localparam logic [3:0] OFF_POWER_CONTROL_REG   = 4'h8;
	localparam logic [3:0] OFF_STATUS = 4'hc;
	// watchdog_ctrl0 fields
	localparam int CTRL0_SWON_BIT = 0;
	localparam int CTRL0_PS_LSB   = 1;
	// watchdog_ctrl1 fields
	localparam int CTRL1_WIN_LSB  = 0;
	localparam int CTRL1_TB_LSB   = 4;
	// power_control_reg field
	localparam int POWER_CONTROL_REG_WV_BIT    = 0;
	// reset values, prescale limit and reserved codes
	localparam logic [4:0] PS_RESET   = 5'h0b;
	localparam logic [4:0] PS_MAX     = 5'h12;
	localparam logic [2:0] WIN_FULL   = 3'h7;
	localparam logic [2:0] TB_RESERVED = 3'h7;
	// modes
	localparam logic [1:0] MODE_OFF   = 2'h0;
	localparam logic [1:0] MODE_SOFT  = 2'h1;
	localparam logic [1:0] MODE_AWAKE = 2'h2;
	localparam logic [1:0] MODE_ON    = 2'h3;
	// timebases
	localparam logic [2:0] TB_LFINT = 3'h0;
	localparam logic [2:0] TB_MFINT = 3'h1;
	localparam logic [2:0] TB_SECONDARY_OSC  = 3'h2;
	// base division and counter geometry
	localparam int BASE_DIV_LOG2 = 5;
	localparam int CNT_W         = 24;
endpackage

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
	logic		clock_i = 0, rst_i = 1, ce_i = 1, por_i = 1;
	logic [1:0]	mode_cfg_i = 2'h3;
	logic [4:0]	prescale_cfg_i = 5'h1f, ps;
	logic [2:0]	timebase_cfg_i = 3'h7, window_cfg_i = 3'h7;
	logic		tick_lf_i = 0, tick_mf_i = 0, tick_secondary_osc_i = 0;
	logic		sleep_i = 0, idle_i = 0, ost_busy_i = 0, clear_op_i = 0;
	logic [3:0]	addr_i = 4'h0;
	logic [7:0]	wdata_i = 8'h00, rdata_o, d;
	logic		wr_i = 0, rd_i = 0, rst_req_o, rst_cause_o, wake_o, run;
	logic		timeout_flag_n_o, seen_req = 0, seen_wake = 0;
	int		n_fail = 0, total_checks = 0;

	wwd_top dut (.*);

	always #5 clock_i = ~clock_i;

	// sticky capture, since both pulses stand one cycle only
	always @(posedge clock_i) begin
		if (rst_req_o === 1'b1) seen_req <= 1'b1;
		if (wake_o === 1'b1) seen_wake <= 1'b1;
	end

	// model: ticks to expiry; reserved codes fall back to the shortest
	function automatic int per(input logic [4:0] c);
		return (c <= 5'h12) ? (32 << c) : 32;
	endfunction

	task automatic chk(input string nm, input logic [7:0] s, e);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clock_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge clock_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	// slow ticks held several cycles so the synchroniser sees each one
	task automatic tk(input int n, input int sel);
		repeat (n) begin
			@(posedge clock_i);
			tick_lf_i <= (sel == 0);
			tick_mf_i <= (sel == 1);
			tick_secondary_osc_i <= (sel == 2);
			repeat (3) @(posedge clock_i);
			{tick_lf_i, tick_mf_i, tick_secondary_osc_i} <= 3'h0;
			repeat (2) @(posedge clock_i);
		end
		repeat (6) @(posedge clock_i);
		#1;
	endtask

	task automatic clr_op;
		@(posedge clock_i);
		clear_op_i <= 1'b1;
		@(posedge clock_i);
		clear_op_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		#1;
	endtask

	task automatic setup(input logic [1:0] m, input logic [2:0] t, w,
			input logic [4:0] p, input logic sw);
		@(posedge clock_i);
		mode_cfg_i <= m;
		rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		wr(4'h4, {1'b0, t, 1'b0, w});
		wr(4'h0, {2'h0, p, sw});
		#1 seen_req = 0;
		seen_wake = 0;
	endtask

	task automatic ev(input logic r, w);
		chk("rst_req", {7'h0, seen_req}, {7'h0, r});
		chk("wake", {7'h0, seen_wake}, {7'h0, w});
		seen_req = 0;
		seen_wake = 0;
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// hang guard, well beyond the expected run of some 8k cycles
	initial begin
		#500000;
		n_fail++;
		final_report;
	end

	initial begin
		void'($urandom(80777));
		repeat (12) @(posedge clock_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		rd(4'h0); chk("ctrl0", d, 8'h16);
		rd(4'h4); chk("ctrl1", d, 8'h07);
		rd(4'h8); chk("power_control_reg", d, 8'h01);
		rd(4'h2); chk("unmapped", d, 8'h00);
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			ps = (i < 3) ? 5'(i) : 5'(19 + $urandom % 13);
			setup(2'h3, 3'h0, 3'h7, ps, 1'b0);
			tk(per(ps) - 1, 0); ev(1'b0, 1'b0);
			tk(1, 0); ev(1'b1, 1'b0);
			chk("cause", {7'h0, rst_cause_o}, 8'h00);
		end
		$display("test time-out done");
		for (int s = 0; s < 3; s++) begin
			setup(2'h3, 3'(s), 3'h7, 5'h00, 1'b0);
			tk(32, (s + 1) % 3); ev(1'b0, 1'b0);
			tk(32, s); ev(1'b1, 1'b0);
		end
		$display("test time base done");
		for (int k = 0; k < 16; k++) begin
			setup(2'(k >> 2), 3'h0, 3'h7, 5'h00, k[1]);
			@(posedge clock_i);
			sleep_i <= k[0];
			run = (k >= 12) || (k / 4 == 2 && !k[0]) || (k / 4 == 1 && k[1]);
			rd(4'hc); chk("running", {7'h0, d[0]}, {7'h0, run});
			tk(32, 0); ev(run && !k[0], run && k[0]);
		end
		sleep_i <= 1'b0;
		setup(2'h3, 3'h0, 3'h7, 5'h00, 1'b0);
		@(posedge clock_i);
		idle_i <= 1'b1;
		tk(32, 0); ev(1'b0, 1'b1);
		idle_i <= 1'b0;
		$display("test modes done");
		setup(2'h3, 3'h0, 3'h3, 5'h00, 1'b0);
		tk(12, 0); rd(4'h0); clr_op; ev(1'b1, 1'b0);
		chk("cause", {7'h0, rst_cause_o}, 8'h01);
		rd(4'h8); chk("power_control_reg", d, 8'h00);
		wr(4'h8, 8'h01); rd(4'h8); chk("power_control_reg", d, 8'h01);
		setup(2'h3, 3'h0, 3'h3, 5'h00, 1'b0);
		tk(20, 0); clr_op; ev(1'b1, 1'b0);
		setup(2'h3, 3'h0, 3'h3, 5'h00, 1'b0);
		tk(20, 0); rd(4'h0); clr_op; ev(1'b0, 1'b0);
		tk(31, 0); ev(1'b0, 1'b0);
		tk(1, 0); ev(1'b1, 1'b0);
		wr(4'h8, 8'h01); rd(4'h8); chk("power_control_reg", d, 8'h01);
		window_cfg_i <= 3'h3;
		setup(2'h3, 3'h0, 3'h7, 5'h00, 1'b0);
		tk(4, 0); rd(4'h0); clr_op; ev(1'b1, 1'b0);
		window_cfg_i <= 3'h7;
		$display("test window done");
		setup(2'h3, 3'h0, 3'h7, 5'h00, 1'b0);
		tk(20, 0); wr(4'h4, 8'h07); tk(20, 0); ev(1'b0, 1'b0);
		@(posedge clock_i);
		ost_busy_i <= 1'b1;
		tk(40, 0); ev(1'b0, 1'b0);
		ost_busy_i <= 1'b0;
		tk(32, 0); ev(1'b1, 1'b0);
		ce_i <= 1'b0;
		tk(40, 0); ev(1'b0, 1'b0);
		ce_i <= 1'b1;
		$display("test clearing done");
		final_report;
	end
endmodule
